// ### design/charge_pkg.sv
// Package of constants and types for the charge cycle sequencer.
package charge_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLOCK_HZ = 40000000;
  localparam int unsigned CLOCK_NS = 25;
  localparam longint unsigned BAD_BATTERY_S = 1800;
  localparam longint unsigned SAFETY_S = 14400;
  localparam int unsigned RECHARGE_DEBOUNCE_US = 1700;
  localparam int unsigned STATUS_CARRIER_HZ = 35000;
  localparam int unsigned TEMP_BLINK_MHZ = 1500;
  localparam int unsigned BAD_BLINK_MHZ = 6100;
  // Least time rounds up.
  localparam int unsigned DEBOUNCE_CYCLES = (RECHARGE_DEBOUNCE_US * 1000 + CLOCK_NS - 1) / CLOCK_NS;
  localparam longint unsigned BAD_BATTERY_CYCLES = BAD_BATTERY_S * CLOCK_HZ;
  localparam longint unsigned SAFETY_CYCLES = SAFETY_S * CLOCK_HZ;
  localparam int unsigned CARRIER_CYCLES = CLOCK_HZ / STATUS_CARRIER_HZ;
  // Half a blink period, in carrier periods.
  localparam int unsigned TEMP_HALF_PERIODS = (STATUS_CARRIER_HZ * 500) / TEMP_BLINK_MHZ;
  localparam int unsigned BAD_HALF_PERIODS = (STATUS_CARRIER_HZ * 500) / BAD_BLINK_MHZ;

  // ************************************************************
  // Current commands in percent of full scale
  // ************************************************************
  localparam logic [6:0] CURRENT_OFF = 7'h00;
  localparam logic [6:0] CURRENT_TRICKLE = 7'h0a;
  localparam logic [6:0] CURRENT_FULL = 7'h64;
  localparam logic [6:0] CURRENT_LOW = 7'h14;

  // Duty cycles in sixteenths of the carrier.
  localparam logic [3:0] DUTY_TEMP_LOW = 4'h1;
  localparam logic [3:0] DUTY_TEMP_HIGH = 4'hf;
  localparam logic [3:0] DUTY_BAD_LOW = 4'h2;
  localparam logic [3:0] DUTY_BAD_HIGH = 4'he;

  typedef enum logic [1:0] {STATUS_CHARGING, STATUS_IDLE, STATUS_BAD, STATUS_TEMP} status_type;

  typedef struct packed {
    logic supplyLockout;
    logic differentialLockout;
    logic suspendIn;
    logic belowTrickle;
    logic belowRecharge;
    logic belowTaper;
    logic thermistorFault;
    logic highCurrentSelect;
  } sense_type;

  // The synchronisers leave reset as if suspended, so no current is commanded before a real sample arrives.
  localparam sense_type SENSE_RESET = '{suspendIn: 1'b1, default: 1'b0};

endpackage : charge_pkg

// ### design/liion_charge_cycle_control.sv
// Charge cycle sequencer for a linear single-cell lithium-ion charger.
`timescale 1ns/10ps
module liion_charge_cycle_control #(
  parameter longint unsigned BAD_BATTERY_COUNT = charge_pkg::BAD_BATTERY_CYCLES,
  parameter longint unsigned SAFETY_COUNT = charge_pkg::SAFETY_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT = charge_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Comparator results, asynchronous
  input wire charge_pkg::sense_type sense,
  // Current command and state
  output logic [6:0] currentCommand,
  output logic constantVoltage,
  output logic badBatteryLatched,
  output logic terminated,
  output charge_pkg::status_type statusCode,
  // Open-drain status pin
  output logic chargeStatusOut,
  output logic chargeStatusOe
);

  // ************************************************************
  // Synchronisers
  // ************************************************************
  charge_pkg::sense_type senseMeta;
  charge_pkg::sense_type senseSync;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      senseMeta <= charge_pkg::SENSE_RESET;
      senseSync <= charge_pkg::SENSE_RESET;
    end else begin
      senseMeta <= sense;
      senseSync <= senseMeta;
    end
  end

  wire logic disabled = senseSync.supplyLockout | senseSync.differentialLockout | senseSync.suspendIn;
  logic disabledPrev;
  wire logic restart = disabledPrev & ~disabled;
  wire logic lowTrickle = senseSync.belowTrickle;

  // ************************************************************
  // Recharge debounce
  // ************************************************************
  logic [31:0] debounce;
  logic aboveRechargeSince;
  wire logic rechargeEvent = senseSync.belowRecharge && debounce == DEBOUNCE_COUNT[31:0] - 32'h1;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      debounce <= 32'h0;
      disabledPrev <= 1'b0;
    end else begin
      disabledPrev <= disabled;
      if (!senseSync.belowRecharge) begin
        debounce <= 32'h0;
      end else if (debounce != DEBOUNCE_COUNT[31:0]) begin
        debounce <= debounce + 32'h1;
      end
    end
  end

  // ************************************************************
  // Cycle timers and latches
  // ************************************************************
  logic [63:0] safetyTimer;
  logic [63:0] trickleTimer;
  wire logic active = ~disabled & ~terminated;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      safetyTimer <= 64'h0;
      trickleTimer <= 64'h0;
      terminated <= 1'b0;
      badBatteryLatched <= 1'b0;
      aboveRechargeSince <= 1'b0;
    end else if (disabled || restart) begin
      safetyTimer <= 64'h0;
      trickleTimer <= 64'h0;
      terminated <= 1'b0;
      badBatteryLatched <= 1'b0;
      aboveRechargeSince <= 1'b0;
    end else begin
      if (!senseSync.belowRecharge) begin
        aboveRechargeSince <= 1'b1;
      end
      if (rechargeEvent) begin
        safetyTimer <= 64'h0;
        terminated <= 1'b0;
      end else if (!terminated && !senseSync.thermistorFault) begin
        safetyTimer <= safetyTimer + 64'h1;
        if (safetyTimer == SAFETY_COUNT - 64'h1) begin
          terminated <= 1'b1;
        end
      end
      if (!lowTrickle) begin
        trickleTimer <= 64'h0;
        // A held trickle count marks a bad-battery stop; a safety stop above trickle must not be undone.
        if (badBatteryLatched && terminated && trickleTimer != 64'h0) begin
          terminated <= 1'b0;
        end
      end else if (active) begin
        trickleTimer <= trickleTimer + 64'h1;
        if (trickleTimer == BAD_BATTERY_COUNT - 64'h1) begin
          badBatteryLatched <= 1'b1;
          terminated <= 1'b1;
          aboveRechargeSince <= 1'b0;
        end
        if (badBatteryLatched && !aboveRechargeSince) begin
          terminated <= 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // Current command
  // ************************************************************
  wire logic [6:0] ccLevel = senseSync.highCurrentSelect ? charge_pkg::CURRENT_FULL : charge_pkg::CURRENT_LOW;
  wire logic charging = active & ~senseSync.thermistorFault;
  wire logic [6:0] next_currentCommand = !charging ? charge_pkg::CURRENT_OFF :
    lowTrickle ? charge_pkg::CURRENT_TRICKLE : ccLevel;
  // Taper comparator says the current has fallen under a tenth of full scale.
  logic tapered;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      currentCommand <= charge_pkg::CURRENT_OFF;
      constantVoltage <= 1'b0;
      tapered <= 1'b0;
    end else begin
      currentCommand <= next_currentCommand;
      constantVoltage <= charging & ~lowTrickle & ~senseSync.belowRecharge;
      tapered <= !active ? 1'b0 : (tapered | (senseSync.belowTaper & ~lowTrickle));
    end
  end

  // ************************************************************
  // Status indication
  // ************************************************************
  wire charge_pkg::status_type next_status =
    (badBatteryLatched && !tapered) ? charge_pkg::STATUS_BAD :
    (active && senseSync.thermistorFault && !tapered) ? charge_pkg::STATUS_TEMP :
    (active && !tapered) ? charge_pkg::STATUS_CHARGING : charge_pkg::STATUS_IDLE;

  logic [15:0] carrier;
  logic [15:0] blink;
  logic blinkHigh;
  wire logic carrierEnd = carrier == 16'(charge_pkg::CARRIER_CYCLES - 1);
  wire logic [15:0] halfPeriods = statusCode == charge_pkg::STATUS_TEMP ?
    16'(charge_pkg::TEMP_HALF_PERIODS) : 16'(charge_pkg::BAD_HALF_PERIODS);
  wire logic [3:0] duty = statusCode == charge_pkg::STATUS_TEMP ?
    (blinkHigh ? charge_pkg::DUTY_TEMP_HIGH : charge_pkg::DUTY_TEMP_LOW) :
    (blinkHigh ? charge_pkg::DUTY_BAD_HIGH : charge_pkg::DUTY_BAD_LOW);
  wire logic [19:0] dutyEdge = 20'(charge_pkg::CARRIER_CYCLES) * {16'h0, duty};
  wire logic pulseLow = {carrier, 4'h0} < dutyEdge;
  wire logic fault = statusCode == charge_pkg::STATUS_TEMP || statusCode == charge_pkg::STATUS_BAD;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      statusCode <= charge_pkg::STATUS_IDLE;
      carrier <= 16'h0;
      blink <= 16'h0;
      blinkHigh <= 1'b0;
      chargeStatusOe <= 1'b0;
    end else begin
      statusCode <= next_status;
      carrier <= carrierEnd ? 16'h0 : carrier + 16'h1;
      if (carrierEnd) begin
        if (blink >= halfPeriods - 16'h1) begin
          blink <= 16'h0;
          blinkHigh <= ~blinkHigh;
        end else begin
          blink <= blink + 16'h1;
        end
      end
      chargeStatusOe <= statusCode == charge_pkg::STATUS_CHARGING || (fault && pulseLow);
    end
  end
  assign chargeStatusOut = 1'b0;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_lockout_off;
    @(posedge clock) disable iff (!nrst) disabled |=> currentCommand == charge_pkg::CURRENT_OFF;
  endproperty
  a_lockout_off: assert property (p_lockout_off) else $error("current while locked out");

  property p_trickle;
    @(posedge clock) disable iff (!nrst) (charging && lowTrickle) |=> currentCommand == charge_pkg::CURRENT_TRICKLE;
  endproperty
  a_trickle: assert property (p_trickle) else $error("trickle level wrong");

  property p_select;
    @(posedge clock) disable iff (!nrst)
      (charging && !lowTrickle && !senseSync.highCurrentSelect) |=> currentCommand == charge_pkg::CURRENT_LOW;
  endproperty
  a_select: assert property (p_select) else $error("low current level wrong");

  property p_terminated_off;
    @(posedge clock) disable iff (!nrst) terminated |=> currentCommand == charge_pkg::CURRENT_OFF;
  endproperty
  a_terminated_off: assert property (p_terminated_off) else $error("current after termination");

  property p_restart_clears;
    @(posedge clock) disable iff (!nrst) restart |=> !badBatteryLatched && !terminated && safetyTimer == 64'h0;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart did not clear");

  property p_recharge;
    @(posedge clock) disable iff (!nrst) (rechargeEvent && !disabled) |=> safetyTimer == 64'h0;
  endproperty
  a_recharge: assert property (p_recharge) else $error("timer not reset on recharge");

  property p_short_dip;
    @(posedge clock) disable iff (!nrst) !senseSync.belowRecharge |=> !rechargeEvent;
  endproperty
  a_short_dip: assert property (p_short_dip) else $error("undebounced recharge");

  property p_status_low;
    @(posedge clock) disable iff (!nrst) statusCode == charge_pkg::STATUS_CHARGING |=> chargeStatusOe;
  endproperty
  a_status_low: assert property (p_status_low) else $error("status not low while charging");

  property p_idle_released;
    @(posedge clock) disable iff (!nrst) statusCode == charge_pkg::STATUS_IDLE |=> !chargeStatusOe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("status driven while idle");

  property p_diff_off;
    @(posedge clock) disable iff (!nrst)
      senseSync.differentialLockout |=> currentCommand == charge_pkg::CURRENT_OFF;
  endproperty
  a_diff_off: assert property (p_diff_off) else $error("current while margin too small");

  property p_suspend_off;
    @(posedge clock) disable iff (!nrst)
      senseSync.suspendIn |=> currentCommand == charge_pkg::CURRENT_OFF;
  endproperty
  a_suspend_off: assert property (p_suspend_off) else $error("current while suspended");

  property p_full;
    @(posedge clock) disable iff (!nrst)
      (charging && !lowTrickle && senseSync.highCurrentSelect) |=> currentCommand == charge_pkg::CURRENT_FULL;
  endproperty
  a_full: assert property (p_full) else $error("full current level wrong");

  property p_cv;
    @(posedge clock) disable iff (!nrst)
      (charging && !lowTrickle && !senseSync.belowRecharge) |=> constantVoltage;
  endproperty
  a_cv: assert property (p_cv) else $error("constant voltage phase missing");

  property p_bad_latch;
    @(posedge clock) disable iff (!nrst)
      (active && !restart && lowTrickle && trickleTimer == BAD_BATTERY_COUNT - 64'h1) |=> badBatteryLatched && terminated;
  endproperty
  a_bad_latch: assert property (p_bad_latch) else $error("bad battery not latched");

  property p_resume;
    @(posedge clock) disable iff (!nrst)
      (!disabled && !restart && !lowTrickle && badBatteryLatched && terminated && trickleTimer != 64'h0)
      |=> !terminated;
  endproperty
  a_resume: assert property (p_resume) else $error("charging not resumed above trickle");

  property p_defective;
    @(posedge clock) disable iff (!nrst)
      (active && !restart && lowTrickle && badBatteryLatched && !aboveRechargeSince) |=> terminated;
  endproperty
  a_defective: assert property (p_defective) else $error("defective battery not stopped");

  property p_latch_hold;
    @(posedge clock) disable iff (!nrst)
      (badBatteryLatched && !disabled && !restart) |=> badBatteryLatched;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("bad battery latch lost");

  property p_safety_end;
    @(posedge clock) disable iff (!nrst)
      (active && !restart && !rechargeEvent && !senseSync.thermistorFault && safetyTimer == SAFETY_COUNT - 64'h1)
      |=> terminated;
  endproperty
  a_safety_end: assert property (p_safety_end) else $error("safety timer did not end charge");

  property p_recharge_restart;
    @(posedge clock) disable iff (!nrst)
      (rechargeEvent && !disabled && !restart && !lowTrickle) |=> !terminated;
  endproperty
  a_recharge_restart: assert property (p_recharge_restart) else $error("recharge did not restart");

endmodule : liion_charge_cycle_control

// ### test/battery_model.sv
// Battery and status pin pull-up model on the far side of the charge sequencer.
`timescale 1ns/10ps
module battery_model (
  // Battery charge level: 0 deep, 1 partial, 2 full
  input wire logic [1:0] level,
  // Open-drain status pin
  input wire logic pinData,
  input wire logic pinOe,
  // Comparator views and resolved pin
  output logic belowTrickle,
  output logic belowRecharge,
  output logic belowTaper,
  output logic statusPin
);
  assign belowTrickle = (level == 2'h0);
  assign belowRecharge = (level != 2'h2);
  // Current tapers only near the float level, so a full cell reads as below one tenth.
  assign belowTaper = (level == 2'h2);
  // The pull-up sets the level whenever the pin is released.
  assign statusPin = pinOe ? pinData : 1'b1;
endmodule : battery_model

// ### test/liion_charge_cycle_control_test.sv
// Self-checking testbench for the charge cycle sequencer.
`timescale 1ns/10ps
module liion_charge_cycle_control_test;
  localparam int unsigned SAFETY = 200;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] level = 2'h0;
  charge_pkg::sense_type drive = 8'h01;
  charge_pkg::sense_type sense;
  logic [6:0] currentCommand;
  logic constantVoltage;
  logic badBatteryLatched;
  logic terminated;
  charge_pkg::status_type statusCode;
  logic chargeStatusOut;
  logic chargeStatusOe;
  logic belowTrickle;
  logic belowRecharge;
  logic belowTaper;
  logic statusPin;
  int errors = 0;
  int testsRun = 0;

  always #12.5 clock = ~clock;

  always_comb begin
    sense = drive;
    sense.belowTrickle = belowTrickle;
    sense.belowRecharge = belowRecharge;
    sense.belowTaper = belowTaper;
  end

  liion_charge_cycle_control #(.BAD_BATTERY_COUNT(50), .SAFETY_COUNT(SAFETY), .DEBOUNCE_COUNT(10)) i_dut (
    .clock(clock), .nrst(nrst), .sense(sense), .currentCommand(currentCommand),
    .constantVoltage(constantVoltage), .badBatteryLatched(badBatteryLatched), .terminated(terminated),
    .statusCode(statusCode), .chargeStatusOut(chargeStatusOut), .chargeStatusOe(chargeStatusOe)
  );

  battery_model i_battery (
    .level(level), .pinData(chargeStatusOut), .pinOe(chargeStatusOe), .belowTrickle(belowTrickle),
    .belowRecharge(belowRecharge), .belowTaper(belowTaper), .statusPin(statusPin)
  );

  task automatic conclude();
    if (errors == 0 && testsRun > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clock);
  endtask : cycles

  // A suspend cycle is the cheapest way to start a fresh charge cycle.
  task automatic restart();
    drive.suspendIn <= 1'b1;
    cycles(6);
    drive.suspendIn <= 1'b0;
    cycles(6);
  endtask : restart

  task automatic waitTerm(input logic exp, input int bound);
    int n;
    n = 0;
    while (terminated !== exp && n < bound) begin
      @(posedge clock);
      n++;
    end
    check(terminated, exp);
    // A bound used up without the expected level has been counted as a mismatch already.
    if (terminated !== exp) begin
      conclude();
    end
  endtask : waitTerm

  // Counts pulled-low samples over one carrier period; either blink phase is accepted.
  task automatic dutyCheck(input int lo, input int hi);
    int low;
    int want;
    low = 0;
    repeat (charge_pkg::CARRIER_CYCLES) begin
      @(posedge clock);
      if (statusPin === 1'b0) begin
        low++;
      end
    end
    want = (low * 2 < charge_pkg::CARRIER_CYCLES) ? lo : hi;
    want = (charge_pkg::CARRIER_CYCLES * want + 15) / 16;
    check(16'(low), 16'(want));
  endtask : dutyCheck

  initial begin
    cycles(4);
    check(currentCommand, charge_pkg::CURRENT_OFF);
    check(chargeStatusOe, 1'b0);
    nrst <= 1'b1;
    cycles(6);
    check(currentCommand, charge_pkg::CURRENT_TRICKLE);
    check(statusPin, 1'b0);
    check(statusCode, charge_pkg::STATUS_CHARGING);
    level <= 2'h1;
    cycles(6);
    check(currentCommand, charge_pkg::CURRENT_FULL);
    drive.highCurrentSelect <= 1'b0;
    cycles(6);
    check(currentCommand, charge_pkg::CURRENT_LOW);
    for (int i = 0; i < 3; i++) begin
      drive[7 - i] <= 1'b1;
      cycles(6);
      check(currentCommand, charge_pkg::CURRENT_OFF);
      drive[7 - i] <= 1'b0;
      cycles(6);
      check(currentCommand, charge_pkg::CURRENT_LOW);
    end
    drive.thermistorFault <= 1'b1;
    cycles(6);
    check(statusCode, charge_pkg::STATUS_TEMP);
    dutyCheck(charge_pkg::DUTY_TEMP_LOW, charge_pkg::DUTY_TEMP_HIGH);
    drive.thermistorFault <= 1'b0;
    drive.highCurrentSelect <= 1'b1;
    level <= 2'h2;
    restart();
    check(constantVoltage, 1'b1);
    cycles(150);
    level <= 2'h1;
    cycles(20);
    level <= 2'h2;
    cycles(100);
    check(terminated, 1'b0);
    waitTerm(1'b1, SAFETY + 20);
    cycles(2);
    check(currentCommand, charge_pkg::CURRENT_OFF);
    level <= 2'h1;
    cycles(5);
    level <= 2'h2;
    cycles(8);
    check(terminated, 1'b1);
    level <= 2'h1;
    cycles(20);
    check(terminated, 1'b0);
    check(currentCommand, charge_pkg::CURRENT_FULL);
    level <= 2'h0;
    restart();
    waitTerm(1'b1, 80);
    check(badBatteryLatched, 1'b1);
    cycles(4);
    check(statusCode, charge_pkg::STATUS_BAD);
    dutyCheck(charge_pkg::DUTY_BAD_LOW, charge_pkg::DUTY_BAD_HIGH);
    level <= 2'h1;
    cycles(6);
    check(terminated, 1'b0);
    level <= 2'h0;
    cycles(6);
    check(terminated, 1'b1);
    restart();
    check(badBatteryLatched, 1'b0);
    conclude();
  end
endmodule : liion_charge_cycle_control_test
